// *** asx_host.sv ***
// module: host controller driving an asynchronous 512k x 16 static memory
// Operation
// - wait the power-up interval after supply before any access
// - write ends at first rising strobe; time data to that edge
// - keep write data valid around the terminating strobe edge
// - write pulse at least turnoff time plus data set-up time
// - write strobe stays high for the whole read
// - address valid no later than select falls for a read
// - address stable from write start until write end
`timescale 1ns/1ps
module asx_host #(
    parameter int ADDR_W = asx_pkg::ADDR_W,
    parameter int DATA_W = asx_pkg::DATA_W,
    parameter int POWER_UP_CYC = asx_pkg::POWER_UP_WAIT_CYC
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rstn,
    // user request
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic [1:0]        req_lanes,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    // memory pins
    output logic [ADDR_W-1:0]      mem_addr,
    output logic                   mem_select_n,
    output logic                   mem_write_n,
    output logic                   mem_output_en_n,
    output logic                   low_lane_enable_n,
    output logic                   high_lane_enable_n,
    input  wire logic [DATA_W-1:0] mem_dq_in,
    output logic [DATA_W-1:0]      mem_dq_out,
    output logic                   mem_dq_oe
);
    // ==================== elaboration checks
    if (ADDR_W != asx_pkg::ADDR_W || DATA_W != 2 * asx_pkg::LANE_W) begin : g_bad_geometry
        $error("asx_host: geometry must be 19 address and 16 data bits");
    end
    if (POWER_UP_CYC < 1 || POWER_UP_CYC >= (1 << asx_pkg::CNT_W)) begin : g_bad_powerup
        $error("asx_host: power-up count out of timer range");
    end

    // ==================== state and timer
    asx_pkg::asx_state_t state_reg;
    asx_pkg::asx_state_t state_next;
    asx_cnt_if           cnt ();
    logic                write_reg;
    logic                rstn_seen_reg;
    logic [DATA_W-1:0]   dq_sync1_reg;
    logic [DATA_W-1:0]   dq_sync2_reg;

    asx_timer u_timer (
        .clock (clock),
        .rstn  (rstn),
        .cnt   (cnt)
    );

    function automatic logic [asx_pkg::CNT_W-1:0] to_cnt(input int cyc);
        to_cnt = asx_pkg::CNT_W'(cyc);
    endfunction : to_cnt

    // ==================== sequencing
    always_comb begin
        state_next = state_reg;
        cnt.load   = 1'b0;
        cnt.value  = '0;
        case (state_reg)
            asx_pkg::ASX_POWERUP: begin
                if (cnt.done) begin
                    state_next = asx_pkg::ASX_IDLE;
                end
            end
            asx_pkg::ASX_IDLE: begin
                if (req_valid && req_ready) begin
                    state_next = asx_pkg::ASX_SETUP;
                end
            end
            asx_pkg::ASX_SETUP: begin
                // address settles one cycle before select, write or output enable falls; lanes fall with the address
                cnt.load  = 1'b1;
                if (write_reg) begin
                    cnt.value  = to_cnt(asx_pkg::WRITE_PULSE_CYC - 1);
                    state_next = asx_pkg::ASX_WPULSE;
                end else begin
                    cnt.value  = to_cnt(asx_pkg::READ_WAIT_CYC);
                    state_next = asx_pkg::ASX_RWAIT;
                end
            end
            asx_pkg::ASX_WPULSE: begin
                if (cnt.done) begin
                    state_next = asx_pkg::ASX_WEND;
                end
            end
            asx_pkg::ASX_WEND: begin
                state_next = asx_pkg::ASX_IDLE;
            end
            asx_pkg::ASX_RWAIT: begin
                if (cnt.done) begin
                    state_next = asx_pkg::ASX_RDONE;
                end
            end
            asx_pkg::ASX_RDONE: begin
                state_next = asx_pkg::ASX_IDLE;
            end
            default: begin
                state_next = asx_pkg::ASX_IDLE;
            end
        endcase
        if (state_reg == asx_pkg::ASX_POWERUP && !rstn_seen_reg) begin
            cnt.load  = 1'b1;
            cnt.value = to_cnt(POWER_UP_CYC);
        end
    end

    // first edge after reset loads the power-up wait, later edges let it run
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rstn_seen_reg <= 1'b0;
        end else begin
            rstn_seen_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= asx_pkg::ASX_POWERUP;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==================== request capture and pins
    // address and lanes latch at acceptance and hold until back in idle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            write_reg          <= 1'b0;
            mem_addr           <= '0;
            mem_dq_out         <= '0;
            low_lane_enable_n  <= asx_pkg::STROBE_IDLE;
            high_lane_enable_n <= asx_pkg::STROBE_IDLE;
        end else if (state_reg == asx_pkg::ASX_IDLE && req_valid) begin
            write_reg          <= req_write;
            mem_addr           <= req_addr;
            mem_dq_out         <= req_wdata;
            low_lane_enable_n  <= ~req_lanes[0];
            high_lane_enable_n <= ~req_lanes[1];
        end else if (state_next == asx_pkg::ASX_IDLE) begin
            low_lane_enable_n  <= asx_pkg::STROBE_IDLE;
            high_lane_enable_n <= asx_pkg::STROBE_IDLE;
        end
    end

    // select and write strobe rise on the same edge; data held past it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mem_select_n    <= asx_pkg::STROBE_IDLE;
            mem_write_n     <= asx_pkg::STROBE_IDLE;
            mem_output_en_n <= asx_pkg::STROBE_IDLE;
            mem_dq_oe       <= 1'b0;
        end else begin
            mem_select_n    <= !(state_next == asx_pkg::ASX_WPULSE ||
                                 state_next == asx_pkg::ASX_RWAIT ||
                                 state_next == asx_pkg::ASX_RDONE);
            mem_write_n     <= !(state_next == asx_pkg::ASX_WPULSE);
            mem_output_en_n <= !(state_next == asx_pkg::ASX_RWAIT ||
                                 state_next == asx_pkg::ASX_RDONE);
            mem_dq_oe       <= (state_next == asx_pkg::ASX_WPULSE ||
                                state_next == asx_pkg::ASX_WEND);
        end
    end

    // ==================== read return
    // read data pass two flops; strobes are stretched to cover that
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dq_sync1_reg <= '0;
            dq_sync2_reg <= '0;
        end else begin
            dq_sync1_reg <= mem_dq_in;
            dq_sync2_reg <= dq_sync1_reg;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            req_ready <= 1'b0;
        end else begin
            rsp_valid <= (state_reg == asx_pkg::ASX_RDONE);
            if (state_reg == asx_pkg::ASX_RDONE) begin
                rsp_rdata <= dq_sync2_reg;
            end
            req_ready <= (state_next == asx_pkg::ASX_IDLE) &&
                         !(state_reg == asx_pkg::ASX_IDLE && req_valid);
        end
    end

    // ==================== assertions
    sequence s_write_pulse;
        !mem_select_n && !mem_write_n;
    endsequence

    a_read_write_high: assert property (@(posedge clock) disable iff (!rstn)
        !mem_output_en_n |-> mem_write_n)
        else $error("write strobe low during read");

    a_write_pulse_len: assert property (@(posedge clock) disable iff (!rstn)
        $fell(mem_write_n) |-> s_write_pulse [*1] ##1 mem_write_n)
        else $error("write pulse length wrong");

    a_strobes_rise_tog: assert property (@(posedge clock) disable iff (!rstn)
        ($rose(mem_write_n)) |-> $rose(mem_select_n))
        else $error("write strobe rose without select");

    a_data_held_end: assert property (@(posedge clock) disable iff (!rstn)
        $rose(mem_write_n) |-> mem_dq_oe && $stable(mem_dq_out))
        else $error("write data not held at write end");

    a_addr_stable_wr: assert property (@(posedge clock) disable iff (!rstn)
        !mem_select_n |-> $stable(mem_addr))
        else $error("address moved while selected");

    a_addr_before_sel: assert property (@(posedge clock) disable iff (!rstn)
        $fell(mem_select_n) |-> $stable(mem_addr))
        else $error("address changed with select fall");

    a_powerup_quiet: assert property (@(posedge clock) disable iff (!rstn)
        state_reg == asx_pkg::ASX_POWERUP |-> mem_select_n && !req_ready)
        else $error("access during power-up wait");

    a_no_drive_read: assert property (@(posedge clock) disable iff (!rstn)
        !mem_output_en_n |-> !mem_dq_oe)
        else $error("host drives bus during read");

    a_read_resp_time: assert property (@(posedge clock) disable iff (!rstn)
        $fell(mem_output_en_n) |-> !mem_output_en_n [*3] ##1 (mem_output_en_n && rsp_valid))
        else $error("read response timing wrong");
endmodule : asx_host

// *** asx_pkg.sv ***
// package: constants and types for the async sram host controller
package asx_pkg;
    // ==================== geometry
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    // ==================== timing
    localparam int CLK_PERIOD_NS          = 40;
    localparam int POWER_UP_WAIT_US       = 100;
    localparam int POWER_UP_WAIT_CYC      = (POWER_UP_WAIT_US * 1000 + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
    localparam int WRITE_TURNOFF_TIME_NS  = 5;
    localparam int WRITE_DATA_SETUP_NS    = 5;
    localparam int WRITE_PULSE_NS         = WRITE_TURNOFF_TIME_NS + WRITE_DATA_SETUP_NS;
    localparam int WRITE_PULSE_CYC_RAW    = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_CYC        = (WRITE_PULSE_CYC_RAW < 1) ? 1 : WRITE_PULSE_CYC_RAW;
    localparam int READ_ACCESS_NS         = 10;
    localparam int READ_WAIT_CYC_RAW      = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_WAIT_CYC          = (READ_WAIT_CYC_RAW < 1) ? 1 : READ_WAIT_CYC_RAW;
    localparam int CNT_W                  = 16;
    // ==================== reset values of the pins
    localparam logic STROBE_IDLE = 1'b1;
    // ==================== states
    typedef enum logic [2:0] {
        ASX_POWERUP = 3'b000,
        ASX_IDLE    = 3'b001,
        ASX_SETUP   = 3'b010,
        ASX_WPULSE  = 3'b011,
        ASX_WEND    = 3'b100,
        ASX_RWAIT   = 3'b101,
        ASX_RDONE   = 3'b110
    } asx_state_t;
endpackage : asx_pkg

// *** asx_cnt_if.sv ***
// interface: countdown timer request and status
`timescale 1ns/1ps
interface asx_cnt_if;
    logic                    load;
    logic [asx_pkg::CNT_W-1:0] value;
    logic                    done;
    modport ctrl (output load, output value, input done);
    modport tmr  (input load, input value, output done);
endinterface : asx_cnt_if

// *** asx_timer.sv ***
// module: loadable countdown used for the power-up and strobe waits
`timescale 1ns/1ps
module asx_timer (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // timer port
    asx_cnt_if.tmr   cnt
);
    logic [asx_pkg::CNT_W-1:0] count_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
        end else if (cnt.load) begin
            count_reg <= cnt.value;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign cnt.done = (count_reg == '0) && !cnt.load;
endmodule : asx_timer

// *** asx_sram_model.sv ***
// partner model: behavioural asynchronous 512k x 16 static memory
`timescale 1ns/1ps
module asx_sram_model (
    // memory pins
    addr,
    select_n,
    write_n,
    output_en_n,
    low_lane_enable_n,
    high_lane_enable_n,
    // data bus
    bus_in,
    dev_out,
    dev_oe
);
    input  wire logic [18:0] addr;
    input  wire logic        select_n;
    input  wire logic        write_n;
    input  wire logic        output_en_n;
    input  wire logic        low_lane_enable_n;
    input  wire logic        high_lane_enable_n;
    input  wire logic [15:0] bus_in;
    output logic      [15:0] dev_out;
    output logic      [1:0]  dev_oe;
    // ==================== storage
    // sparse store: the full array would be wasted on a short run
    logic [15:0] mem [logic [18:0]];
    logic [15:0] wr;
    logic [15:0] rd;
    // ==================== write during the strobe overlap only
    // explicit list: storing into the array must not wake this process again
    always @(select_n or write_n or addr or bus_in or
             low_lane_enable_n or high_lane_enable_n) begin
        if (!select_n && !write_n) begin
            wr = mem.exists(addr) ? mem[addr] : 16'h0000;
            if (!low_lane_enable_n) wr[7:0] = bus_in[7:0];
            if (!high_lane_enable_n) wr[15:8] = bus_in[15:8];
            mem[addr] = wr;
        end
    end
    // ==================== read drive per lane
    // floated lanes show the inverse of the stored byte, so a missed drive fails
    always @(addr or select_n or write_n or output_en_n or
             low_lane_enable_n or high_lane_enable_n) begin
        rd = mem.exists(addr) ? mem[addr] : 16'h0000;
        dev_oe[0] = !select_n && write_n && !output_en_n && !low_lane_enable_n;
        dev_oe[1] = !select_n && write_n && !output_en_n && !high_lane_enable_n;
        dev_out[7:0] = dev_oe[0] ? rd[7:0] : ~rd[7:0];
        dev_out[15:8] = dev_oe[1] ? rd[15:8] : ~rd[15:8];
    end
endmodule : asx_sram_model

// *** tb_async_sram_x16_access.sv ***
// testbench: host controller against the behavioural static memory
`timescale 1ns/1ps
module tb_async_sram_x16_access;
    localparam int PU = 4;
    localparam logic [18:0] ADDRS [4] = '{19'h00000, 19'h7FFFF, 19'h2AAAA, 19'h55555};
    // ==================== signals
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [18:0] req_addr = 19'h00000;
    logic [15:0] req_wdata = 16'h0000;
    logic [1:0]  req_lanes = 2'h0;
    logic        req_ready, rsp_valid, sel_n, we_n, oe_n, lo_n, hi_n, dq_oe;
    logic [15:0] rsp_rdata, dq_out, dev_out, bus;
    logic [18:0] mem_addr;
    logic [1:0]  dev_oe;
    logic [15:0] shadow [4] = '{default: 16'h0000};
    logic        p_sel = 1'b1;
    logic        p_we = 1'b1;
    logic [18:0] p_addr = 19'h00000;
    logic [15:0] p_dq = 16'h0000;
    logic [31:0] r;
    int          fail_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          pu_cnt = 0;
    int          seed = 57928;
    int          n;
    always #20 clock = ~clock;
    assign bus = dq_oe ? dq_out : dev_out;
    // ==================== design and memory
    asx_host #(.POWER_UP_CYC(PU)) dut_u (.clock(clock), .rstn(rstn), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_lanes(req_lanes), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .mem_select_n(sel_n),
        .mem_write_n(we_n), .mem_output_en_n(oe_n), .low_lane_enable_n(lo_n),
        .high_lane_enable_n(hi_n), .mem_dq_in(bus), .mem_dq_out(dq_out), .mem_dq_oe(dq_oe));
    asx_sram_model dev_u (.addr(mem_addr), .select_n(sel_n), .write_n(we_n),
        .output_en_n(oe_n), .low_lane_enable_n(lo_n), .high_lane_enable_n(hi_n),
        .bus_in(bus), .dev_out(dev_out), .dev_oe(dev_oe));
    // ==================== helpers
    function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] d, logic [1:0] l);
        merge = {l[1] ? d[15:8] : o[15:8], l[0] ? d[7:0] : o[7:0]};
    endfunction : merge
    task automatic chk(input string name, input logic [18:0] exp, input logic [18:0] got);
        check_count++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task automatic wait_ready;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (req_ready !== 1'b1 && n < 100);
    endtask : wait_ready
    // request held until the edge that takes it
    task automatic take(input logic wr, input int ai, input logic [15:0] d, input logic [1:0] l);
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= ADDRS[ai];
        req_wdata <= d;
        req_lanes <= l;
        wait_ready();
        @(posedge clock);
        req_valid <= 1'b0;
    endtask : take
    task automatic access(input logic wr, input int ai, input logic [15:0] d, input logic [1:0] l);
        logic [15:0] m;
        m = {{8{l[1]}}, {8{l[0]}}};
        take(wr, ai, d, l);
        if (wr) begin
            shadow[ai] = merge(shadow[ai], d, l);
            wait_ready();
            chk("write done", 19'h00001, req_ready);
        end else begin
            n = 0;
            do begin
                @(negedge clock);
                n++;
            end while (rsp_valid !== 1'b1 && n < 100);
            // setup, wait count plus one, done cycle, then the response edge
            chk("read latency", 19'(asx_pkg::READ_WAIT_CYC + 4), n[18:0]);
            chk("read data", shadow[ai] & m, rsp_rdata & m);
        end
    endtask : access
    // ==================== pin monitor
    always @(negedge clock) begin
        if (!rstn) begin
            pu_cnt = 0;
            chk("reset pins", 19'h0001F, {sel_n, we_n, oe_n, lo_n, hi_n});
        end else begin
            pu_cnt++;
            if (pu_cnt <= PU) chk("power-up idle", 19'h00001, sel_n);
            if (!sel_n && !p_sel) chk("addr hold", p_addr, mem_addr);
            if (!sel_n && !oe_n) chk("strobe in read", 19'h00001, we_n);
            if (!p_sel && !p_we && sel_n) chk("end together", 19'h00001, we_n);
            if (!p_sel && !p_we && sel_n) chk("data at end", {1'b1, p_dq}, {dq_oe, dq_out});
            if (dq_oe) chk("bus clash", 19'h00000, dev_oe);
        end
        p_sel = sel_n;
        p_we = we_n;
        p_addr = mem_addr;
        p_dq = dq_out;
    end
    // hang guard: far above the few hundred cycles the run needs
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    // ==================== scenarios
    initial begin
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        wait_ready();
        chk("power-up wait", 19'h00001, n >= PU);
        $display("power-up done");
        for (int i = 0; i < 4; i++) access(1'b1, i, 16'h0000, 2'h3);
        for (int l = 0; l < 4; l++) begin
            access(1'b1, 1, 16'hA5C3 ^ l[15:0], l[1:0]);
            access(1'b0, 1, 16'h0000, 2'h3);
            access(1'b0, 1, 16'h0000, l[1:0]);
        end
        $display("lane codes done");
        for (int k = 0; k < 60; k++) begin
            r = $random(seed);
            access(r[0], int'(r[2:1]), r[31:16], r[4:3]);
        end
        $display("random traffic done");
        take(1'b0, 2, 16'h0000, 2'h3);
        repeat (2) @(posedge clock);
        rstn <= 1'b0;
        @(posedge clock);
        rstn <= 1'b1;
        access(1'b0, 2, 16'h0000, 2'h3);
        $display("mid-run reset done");
        stop_test();
    end
endmodule : tb_async_sram_x16_access
